// ===== inc/spi_resp_pkg.sv
// Constants, frame layout and state types for the SPI register read responder.
// Assumes a 32-bit frame link and a single core clock of 250 MHz.
//
// Operation
// - 32-bit frames, bit 31 first, bit 0 last
// - Only upper seven address bits select a pair
// - Normal reply next transfer unless error seen
// - Any error swaps reply for error frame
// - Register pair captured at select rising edge
// - Clock idles low, sample rise, shift fall
// - Ignore data and clock while deselected
// - Echo 0110; odd byte high, even low
package spi_resp_pkg;

   // ****************************************************************
   // Frame geometry
   // ****************************************************************
   localparam int FRAME_BITS     = 32;
   localparam int CNT_W          = 6;
   localparam int CMD_HI         = 31;
   localparam int CMD_LO         = 28;
   localparam int ADDR_HI        = 23;
   localparam int ADDR_LO        = 17;
   localparam int ADDR_W         = 7;
   localparam int HDR_W          = 24;
   localparam int CRC_W          = 8;

   // ****************************************************************
   // Codes and reset values
   // ****************************************************************
   localparam logic [3:0]  CMD_READ      = 4'hc;
   localparam logic [3:0]  ECHO_READ     = 4'h6;
   localparam logic [1:0]  ST_ERROR      = 2'h3;
   localparam logic [1:0]  SF_NONE       = 2'h0;
   localparam logic [1:0]  SF_SPI        = 2'h1;
   localparam logic [1:0]  SF_MISO       = 2'h2;
   localparam logic [1:0]  SF_OTHER      = 2'h3;
   localparam logic [31:0] TX_RESET     = 32'h0000_0000;
   localparam logic [23:0] HDR_RESET    = 24'h00_0000;
   localparam logic [6:0]  ADDR_RESET   = 7'h00;
   localparam int          SYNC_STAGES  = 2;

   typedef enum logic [1:0] {
      st_idle,
      st_fetch,
      st_build,
      st_seal
   } core_state_t;

endpackage : spi_resp_pkg

// ===== inc/spi_link_if.sv
// Carrier between the serial link logic and the core logic.
// Assumes cmd_word stays still while select is high and tx_word while select is low.
`timescale 1ns/10ps
interface spi_link_if;
   import spi_resp_pkg::*;

   logic [FRAME_BITS-1:0] cmd_word;   // Last received frame, link domain
   logic                  frame_full; // Exactly 32 bits were clocked in
   logic [FRAME_BITS-1:0] tx_word;    // Reply for next frame, core domain

   modport link (output cmd_word, output frame_full, input tx_word);
   modport core (input cmd_word, input frame_full, output tx_word);
endinterface : spi_link_if

// ===== src/spi_link_shifter.sv
// Serial side of the responder, clocked by the host serial clock.
// Assumes the serial clock is quiet while select is high.
`timescale 1ns/10ps
module spi_link_shifter
   import spi_resp_pkg::*;
(
   // Link pins
   input  wire logic sclk,
   input  wire logic ss_b,
   input  wire logic mosi,
   output logic      miso,
   // Core side
   spi_link_if.link  lnk
);

   logic             frame_rst_b;
   logic [CNT_W-1:0] bit_cnt;
   logic [FRAME_BITS-1:0] rx_sr;
   logic [FRAME_BITS-1:0] tx_sr;
   logic             len_ok;

   // Deselect holds the bit counter and transmit shifter in reset, so stray edges do nothing
   assign frame_rst_b = ~ss_b;

   // ****************************************************************
   // Receive on rising edge, MSB first
   // ****************************************************************
   always_ff @(posedge sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         bit_cnt <= '0;
      end else if (bit_cnt <= CNT_W'(FRAME_BITS)) begin
         bit_cnt <= bit_cnt + CNT_W'(1);
      end
   end

   // Shift register keeps its content between frames for the core
   always_ff @(posedge sclk) begin
      if (!ss_b) begin
         rx_sr <= {rx_sr[FRAME_BITS-2:0], mosi};
      end
   end

   // Length verdict must outlive deselect, which clears the counter;
   // a frame with no clock edges at all leaves the previous verdict
   always_ff @(posedge sclk) begin
      if (!ss_b) begin
         len_ok <= (bit_cnt == CNT_W'(FRAME_BITS - 1));
      end
   end

   assign lnk.cmd_word   = rx_sr;
   assign lnk.frame_full = len_ok;

   // ****************************************************************
   // Transmit on falling edge; first bit shown straight from tx_word
   // ****************************************************************
   always_ff @(negedge sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         tx_sr <= '0;
      end else if (bit_cnt == CNT_W'(1)) begin
         tx_sr <= {lnk.tx_word[FRAME_BITS-2:0], 1'b0};
      end else begin
         tx_sr <= {tx_sr[FRAME_BITS-2:0], 1'b0};
      end
   end

   // Bit 31 must be valid before the first rising edge
   assign miso = (bit_cnt == '0) ? lnk.tx_word[FRAME_BITS-1] : tx_sr[FRAME_BITS-1];

endmodule : spi_link_shifter

// ===== src/spi_register_read_responder.sv
// Top of the SPI register read responder.
// Decodes read commands, snapshots a register pair at select rise
// and prepares the reply frame for the next transfer.
// Assumes an external register array with same-cycle read data and an
// external CRC generator answering in the same core clock cycle.
`timescale 1ns/10ps
module spi_register_read_responder
   import spi_resp_pkg::*;
(
   // Core clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // Serial link
   input  wire logic              sclk,
   input  wire logic              ss_b,
   input  wire logic              mosi,
   output logic                   miso,
   output logic                   miso_oe,
   // Register array read port
   output logic [ADDR_W-1:0]      reg_word_addr,
   input  wire logic [15:0]       reg_pair_data,
   // Status and error inputs
   input  wire logic [1:0]        basic_status_field,
   input  wire logic              spi_error,
   input  wire logic              miso_error,
   // CRC generator
   output logic [HDR_W-1:0]       resp_hdr,
   input  wire logic [CRC_W-1:0]  resp_crc,
   // Event
   output logic                   read_done
);

   spi_link_if lnk ();

   logic [SYNC_STAGES-1:0] ss_sync;
   logic                   ss_prev;
   logic                   ss_rise;
   logic                   sel_q;
   logic                   sel_sync;
   logic                   cmd_is_read;
   logic [1:0]             fault;
   logic [1:0]             next_fault;
   logic [HDR_W-1:0]       next_hdr;
   logic [FRAME_BITS-1:0]  tx_word;
   core_state_t            state;

   // ****************************************************************
   // Link logic on the serial clock
   // ****************************************************************
   spi_link_shifter u_link (
      .sclk (sclk),
      .ss_b (ss_b),
      .mosi (mosi),
      .miso (miso),
      .lnk  (lnk)
   );

   assign lnk.tx_word = tx_word;

   // ****************************************************************
   // Select crossing: two flops, then edge detect on the second
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ss_sync <= '1;
         ss_prev <= 1'b1;
      end else begin
         ss_sync <= {ss_sync[SYNC_STAGES-2:0], ss_b};
         ss_prev <= ss_sync[SYNC_STAGES-1];
      end
   end

   assign ss_rise = ss_sync[SYNC_STAGES-1] & ~ss_prev;

   // Drive enable follows select through its own two flops, as late as the synchronised select
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sel_q    <= 1'b0;
         sel_sync <= 1'b0;
      end else begin
         sel_q    <= ~ss_b;
         sel_sync <= sel_q;
      end
   end

   assign miso_oe = sel_sync;

   // Link words are quasi-static while select is high, so they are
   // read directly after the synchronised select edge
   assign cmd_is_read = lnk.frame_full
                      & (lnk.cmd_word[CMD_HI:CMD_LO] == CMD_READ);

   // ****************************************************************
   // Fault classification at frame end
   // ****************************************************************
   always_comb begin
      if (spi_error || !lnk.frame_full) begin
         next_fault = SF_SPI;
      end else if (miso_error) begin
         next_fault = SF_MISO;
      end else if (!cmd_is_read) begin
         next_fault = SF_OTHER;
      end else begin
         next_fault = SF_NONE;
      end
   end

   // ****************************************************************
   // Sequencer: fetch pair, build header, seal with CRC
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= st_idle;
      end else begin
         case (state)
            st_idle: begin
               if (ss_rise) begin
                  state <= st_fetch;
               end
            end
            st_fetch: begin
               state <= st_build;
            end
            st_build: begin
               state <= st_seal;
            end
            st_seal: begin
               state <= st_idle;
            end
            default: begin
               state <= st_idle;
            end
         endcase
      end
   end

   // Address and fault are latched at the select rise
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_word_addr <= ADDR_RESET;
         fault         <= SF_NONE;
      end else if (state == st_idle && ss_rise) begin
         reg_word_addr <= lnk.cmd_word[ADDR_HI:ADDR_LO];
         fault         <= next_fault;
      end
   end

   // Reply header, built from the pair snapshot or the fault cause
   always_comb begin
      if (fault == SF_NONE) begin
         next_hdr = {ECHO_READ, basic_status_field, 2'b00,
                     reg_pair_data[15:8], reg_pair_data[7:0]};
      end else begin
         next_hdr = {ECHO_READ, ST_ERROR, 16'h0000, fault};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         resp_hdr <= HDR_RESET;
      end else if (state == st_fetch) begin
         resp_hdr <= next_hdr;
      end
   end

   // Frame is sealed only after the CRC for the new header settled
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_word <= TX_RESET;
      end else if (state == st_seal) begin
         tx_word <= {resp_hdr, resp_crc};
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         read_done <= 1'b0;
      end else begin
         read_done <= (state == st_seal);
      end
   end

endmodule : spi_register_read_responder

// ===== sim/spi_host_model.sv
// Behavioural SPI host that sends one frame per call and captures the reply.
// Assumes the testbench calls xfer only while no other frame is running.
`timescale 1ns/10ps
module spi_host_model (
   // Link pins
   output logic      sclk,
   output logic      ss_b,
   output logic      mosi,
   input  wire logic miso
);
   // Idle state: deselected, clock low
   initial begin
      sclk = 1'b0;
      ss_b = 1'b1;
      mosi = 1'b0;
   end
   // One frame; nbits below 32 makes a short frame on purpose
   task automatic xfer(input logic [31:0] cmd, input int nbits, output logic [31:0] rsp);
      rsp  = 32'h0000_0000;
      ss_b = 1'b0;
      for (int i = 31; i > 31 - nbits; i--) begin
         mosi = cmd[i];
         #62.5;
         // Sample just before the rise, while miso is still settled
         rsp = {rsp[30:0], miso};
         sclk = 1'b1;
         #62.5 sclk = 1'b0;
      end
      #62.5 ss_b = 1'b1;
      mosi = ~mosi; // Released line shows no stale value
      #100; // Gap well above the 8 clk minimum
   endtask : xfer
endmodule : spi_host_model

// ===== sim/spi_register_read_responder_sva.sv
// Checker on the top ports of the responder, bound after the module.
// Assumes the host keeps select high for at least 25 core clocks.
`timescale 1ns/10ps
module spi_resp_sva
   import spi_resp_pkg::*;
(
   // Core clock and reset
   input wire logic              clk,
   input wire logic              rst_b,
   // Serial link
   input wire logic              sclk,
   input wire logic              ss_b,
   input wire logic              mosi,
   input wire logic              miso,
   input wire logic              miso_oe,
   // Register, status and CRC side
   input wire logic [ADDR_W-1:0] reg_word_addr,
   input wire logic [15:0]       reg_pair_data,
   input wire logic [1:0]        basic_status_field,
   input wire logic              spi_error,
   input wire logic              miso_error,
   input wire logic [HDR_W-1:0]  resp_hdr,
   input wire logic [CRC_W-1:0]  resp_crc,
   input wire logic              read_done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Select sync is two clocks late, five gives margin
   oe_off_a: assert property (ss_b [*5] |-> !miso_oe) else $error("oe high while off");
   oe_on_a: assert property (!ss_b [*5] |-> miso_oe) else $error("oe low while on");
   load_time_a: assert property ($rose(ss_b) |-> ##[4:8] read_done)
      else $error("reply not loaded in time");
   done_once_a: assert property (read_done |=> !read_done [*8])
      else $error("reply loaded twice");
   done_gap_a: assert property (read_done |-> ss_b && $past(ss_b, 4))
      else $error("reply loaded while selected");
   echo_code_a: assert property (read_done |-> resp_hdr[23:20] == ECHO_READ)
      else $error("bad echo code");
   err_zero_a: assert property (read_done && resp_hdr[19:18] == ST_ERROR |-> !(|resp_hdr[17:2]))
      else $error("error reply data not zero");
   good_data_a: assert property (read_done && resp_hdr[19:18] != ST_ERROR
      |-> resp_hdr[17:0] == {2'b00, reg_pair_data}) else $error("good reply data wrong");
   hdr_hold_a: assert property (!ss_b |-> $stable(resp_hdr) && $stable(reg_word_addr))
      else $error("reply moved in frame");
   cover property (read_done && resp_hdr[19:18] == ST_ERROR);
   cover property (read_done && resp_hdr[19:18] != ST_ERROR);
   cover property ($fell(ss_b));
endmodule : spi_resp_sva
bind spi_register_read_responder spi_resp_sva chk_u (
   .clk(clk), .rst_b(rst_b), .sclk(sclk), .ss_b(ss_b), .mosi(mosi), .miso(miso),
   .miso_oe(miso_oe), .reg_word_addr(reg_word_addr), .reg_pair_data(reg_pair_data),
   .basic_status_field(basic_status_field), .spi_error(spi_error),
   .miso_error(miso_error), .resp_hdr(resp_hdr), .resp_crc(resp_crc), .read_done(read_done));

// ===== sim/spi_register_read_responder_tb.sv
// Self-checking bench: host model on the link, register and CRC stand-ins.
// Assumes replies are loaded well inside the 100 ns host gap.
`timescale 1ns/10ps
module spi_register_read_responder_tb;
   import spi_resp_pkg::*;
   logic              clk, rst_b, sclk, ss_b, mosi, miso, miso_oe;
   logic              spi_error, miso_error, read_done;
   logic [ADDR_W-1:0] reg_word_addr;
   logic [1:0]        basic_status_field;
   logic [HDR_W-1:0]  resp_hdr;
   logic [7:0]        bank;
   logic [31:0]       rsp;
   int                err_total, samples_checked;
   // ****************************************************************
   // Stand-ins and instances
   // ****************************************************************
   wire logic [15:0] reg_pair_data = {1'b1, reg_word_addr, {1'b0, reg_word_addr} ^ bank};
   wire logic [7:0]  resp_crc = resp_hdr[23:16] ^ resp_hdr[15:8] ^ resp_hdr[7:0];
   spi_host_model host_u (.sclk(sclk), .ss_b(ss_b), .mosi(mosi), .miso(miso));
   spi_register_read_responder dut_u (.clk(clk), .rst_b(rst_b), .sclk(sclk), .ss_b(ss_b),
      .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .reg_word_addr(reg_word_addr),
      .reg_pair_data(reg_pair_data), .basic_status_field(basic_status_field),
      .spi_error(spi_error), .miso_error(miso_error), .resp_hdr(resp_hdr),
      .resp_crc(resp_crc), .read_done(read_done));
   // Frame with its stand-in CRC appended
   function automatic logic [31:0] sealed(input logic [23:0] h);
      return {h, h[23:16] ^ h[15:8] ^ h[7:0]};
   endfunction : sealed
   function automatic logic [31:0] rd_cmd(input logic [6:0] a, input logic lo);
      return sealed({CMD_READ, 4'h0, a, lo, 8'h00});
   endfunction : rd_cmd
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         err_total++;
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   // Chained reads; bank moves after each snapshot, so stale data shows
   task automatic t_read();
      logic [6:0]  a [4] = '{7'h00, 7'h55, 7'h7f, 7'h2a};
      logic [31:0] exp;
      exp = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         bank = 8'h3c + 8'(i * 17);
         basic_status_field = 2'(i % 3);
         host_u.xfer(rd_cmd(a[i], i[0]), 32, rsp);
         chk("read reply", exp, rsp);
         exp = sealed({ECHO_READ, 2'(i % 3), 2'b00, 1'b1, a[i], {1'b0, a[i]} ^ bank});
         @(negedge clk);
         bank = ~bank;
      end
      host_u.xfer(rd_cmd(7'h01, 1'b0), 32, rsp);
      chk("last read reply", exp, rsp);
      $display("t_read done");
   endtask : t_read
   // Every refusal cause, each answered in the following frame
   task automatic t_err();
      logic [1:0]  se [5] = '{2'b10, 2'b01, 2'b00, 2'b00, 2'b00};
      logic [3:0]  op [5] = '{CMD_READ, CMD_READ, 4'h8, 4'h1, CMD_READ};
      int          nb [5] = '{32, 32, 32, 32, 31};
      logic [1:0]  cause [5] = '{SF_SPI, SF_MISO, SF_OTHER, SF_OTHER, SF_SPI};
      logic [31:0] exp;
      for (int i = 0; i < 6; i++) begin
         @(negedge clk);
         {spi_error, miso_error} = (i < 5) ? se[i] : 2'b00;
         if (i < 5) host_u.xfer(sealed({op[i], 20'h0_0000}), nb[i], rsp);
         else host_u.xfer(rd_cmd(7'h10, 1'b1), 32, rsp);
         if (i > 0) chk("error reply", exp >> (32 - ((i < 5) ? nb[i] : 32)), rsp);
         if (i < 5) exp = sealed({ECHO_READ, ST_ERROR, 16'h0000, cause[i]});
      end
      @(negedge clk);
      {spi_error, miso_error} = 2'b00;
      $display("t_err done");
   endtask : t_err
   // Clock, reset and sequence
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      {rst_b, spi_error, miso_error, basic_status_field, bank} = '0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_b = 1'b1;
      repeat (5) @(negedge clk);
      t_read();
      t_err();
      complete_run();
   end
   // Watchdog well beyond the eleven frames of about 46 us
   initial begin
      #200000;
      err_total++;
      complete_run();
   end
endmodule : spi_register_read_responder_tb
